//--- src/pdtr_pkg.sv
package pdtr_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int          ADDR_W      = 13;
   localparam int          IDX_W       = 11;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_ASYM     = 11'h644;
   localparam logic [IDX_W-1:0] IDX_LINK     = 11'h646;
   localparam logic [IDX_W-1:0] IDX_DREQ_LO  = 11'h648;
   localparam logic [IDX_W-1:0] IDX_DREQ_HI  = 11'h64A;
   localparam logic [IDX_W-1:0] IDX_SYNC_LO  = 11'h64C;
   localparam logic [IDX_W-1:0] IDX_SYNC_HI  = 11'h64E;
   localparam logic [IDX_W-1:0] IDX_PRSP_LO  = 11'h650;
   localparam logic [IDX_W-1:0] IDX_PRSP_HI  = 11'h652;
   localparam logic [IDX_W-1:0] IDX_RX_LAT   = 11'h660;
   localparam logic [IDX_W-1:0] IDX_TX_LAT   = 11'h662;
   localparam logic [IDX_W-1:0] IDX_WIN_LO   = 11'h644;
   localparam logic [IDX_W-1:0] IDX_WIN_HI   = 11'h663;

   // ------------------------------------------------------------
   // Field positions and reset values
   // ------------------------------------------------------------
   localparam int          ASYM_SIGN_BIT = 15;
   localparam int          ASYM_MAG_W    = 15;
   localparam int          CORR_FRAC_W   = 16;
   localparam int          HI_SEC_LSB    = 14;
   localparam int          HI_NS_W       = 14;
   localparam logic [15:0] ASYM_RST      = 16'h0000;
   localparam logic [15:0] LINK_RST      = 16'h0000;
   localparam logic [15:0] STAMP_RST     = 16'h0000;
   localparam logic [15:0] RX_LAT_RST    = 16'h019F;
   localparam logic [15:0] TX_LAT_RST    = 16'h002D;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      MSG_SYNC, MSG_DELAY_REQ, MSG_PDELAY_REQ, MSG_PDELAY_RESP, MSG_OTHER
   } pdtr_msg_t;

   typedef enum logic [3:0] {
      SEL_ASYM, SEL_LINK, SEL_DREQ_LO, SEL_DREQ_HI, SEL_SYNC_LO, SEL_SYNC_HI,
      SEL_PRSP_LO, SEL_PRSP_HI, SEL_RX_LAT, SEL_TX_LAT, SEL_RSVD, SEL_NONE
   } pdtr_sel_t;

   typedef struct packed {
      logic        valid;
      pdtr_msg_t   kind;
      logic [1:0]  sec;
      logic [29:0] ns;
   } pdtr_stamp_t;

   typedef struct packed {
      logic        valid;
      logic        ingress;
      pdtr_msg_t   kind;
      logic [63:0] field;
   } pdtr_corr_req_t;

   typedef struct packed {
      logic        valid;
      logic [63:0] field;
   } pdtr_corr_rsp_t;

endpackage

//--- src/pdtr_corr_adj.sv
`timescale 1ns/10ps
module pdtr_corr_adj (
   input  wire logic                     i_clk,
   input  wire logic                     i_rst_b,
   input  wire logic [15:0]              i_asym,
   input  wire pdtr_pkg::pdtr_corr_req_t i_req,
   output pdtr_pkg::pdtr_corr_rsp_t      o_rsp
);
   import pdtr_pkg::*;

   // ------------------------------------------------------------
   // Signed asymmetry scaled to correction-field units
   // ------------------------------------------------------------
   logic [63:0] mag_scaled;
   logic [63:0] asym_scaled;
   logic        do_add;
   logic        do_sub;

   // Sign bit turns the 15-bit magnitude negative
   always_comb begin
      mag_scaled  = {33'h0_0000_0000, i_asym[ASYM_MAG_W-1:0], 16'h0000};
      asym_scaled = i_asym[ASYM_SIGN_BIT] ? (64'h0 - mag_scaled) : mag_scaled; // [RULE1]
   end

   // Ingress Sync/Pdelay_Resp add, egress Delay_Req/Pdelay_Req subtract
   always_comb begin
      do_add = i_req.ingress && (i_req.kind == MSG_SYNC || i_req.kind == MSG_PDELAY_RESP);
      do_sub = !i_req.ingress &&
               (i_req.kind == MSG_DELAY_REQ || i_req.kind == MSG_PDELAY_REQ);
   end

   // Registered result, one cycle after the request
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_rsp <= '0;
      end else begin
         o_rsp.valid <= i_req.valid;
         if (do_add) begin
            o_rsp.field <= i_req.field + asym_scaled;                   // [RULE2]
         end else if (do_sub) begin
            o_rsp.field <= i_req.field - asym_scaled;                   // [RULE3]
         end else begin
            o_rsp.field <= i_req.field;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_ingress_add;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_req.valid && i_req.ingress && i_req.kind == MSG_SYNC && !i_asym[15])
      |=> o_rsp.valid &&
          (o_rsp.field == $past(i_req.field) + {33'h0, $past(i_asym[14:0]), 16'h0});
   endproperty
   a_ingress_add: assert property (p_ingress_add) // [RULE2]
      else $error("ingress asymmetry not added");

   property p_egress_sub;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_req.valid && !i_req.ingress && i_req.kind == MSG_PDELAY_REQ && i_asym[15])
      |=> (o_rsp.field == $past(i_req.field) + {33'h0, $past(i_asym[14:0]), 16'h0});
   endproperty
   a_egress_sub: assert property (p_egress_sub) // [RULE3]
      else $error("negative asymmetry not subtracted on egress");

   property p_sign_neg;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_req.valid && i_req.ingress && i_req.kind == MSG_PDELAY_RESP && i_asym[15])
      |=> (o_rsp.field == $past(i_req.field) - {33'h0, $past(i_asym[14:0]), 16'h0});
   endproperty
   a_sign_neg: assert property (p_sign_neg) // [RULE1]
      else $error("sign bit not honoured");

endmodule

//--- src/pdtr_regs.sv
// Operation
// [RULE1] Asymmetry bit 15 is sign of magnitude
// [RULE2] Add asymmetry on ingress Sync, Pdelay_Resp
// [RULE3] Subtract asymmetry on egress Delay_Req, Pdelay_Req
// [RULE4] Link delay is writable, resets to zero
// [RULE5] Delay request egress nanoseconds low word
// [RULE6] Delay request high word: seconds, upper ns
// [RULE7] Sync egress nanoseconds low word
// [RULE8] Sync high word: seconds, upper ns
// [RULE9] Pdelay_Resp egress nanoseconds low word
// [RULE10] Pdelay_Resp high word: seconds, upper ns
// [RULE11] Port 2 receive latency, default 415 ns
// [RULE12] Port 2 transmit latency, default 45 ns
// [RULE13] Reserved offsets read zero, ignore writes
// [RULE14] Capture updates both words together, overwriting
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module pdtr_regs (
   input  wire logic                         i_clk,
   input  wire logic                         i_rst_b,
   // AXI4-Lite write address
   input  wire logic                         i_awvalid,
   output logic                              o_awready,
   input  wire logic [pdtr_pkg::ADDR_W-1:0]  i_awaddr,
   // AXI4-Lite write data
   input  wire logic                         i_wvalid,
   output logic                              o_wready,
   input  wire logic [31:0]                  i_wdata,
   input  wire logic [3:0]                   i_wstrb,
   // AXI4-Lite write response
   output logic                              o_bvalid,
   input  wire logic                         i_bready,
   output logic [1:0]                        o_bresp,
   // AXI4-Lite read address
   input  wire logic                         i_arvalid,
   output logic                              o_arready,
   input  wire logic [pdtr_pkg::ADDR_W-1:0]  i_araddr,
   // AXI4-Lite read data
   output logic                              o_rvalid,
   input  wire logic                         i_rready,
   output logic [31:0]                       o_rdata,
   output logic [1:0]                        o_rresp,
   // Port 1 egress time stamp capture
   input  wire pdtr_pkg::pdtr_stamp_t        i_stamp,
   // Correction field path
   input  wire pdtr_pkg::pdtr_corr_req_t     i_corr_req,
   output pdtr_pkg::pdtr_corr_rsp_t          o_corr_rsp,
   // Configured delays to the time stamp logic
   output logic [15:0]                       o_link_delay,
   output logic [15:0]                       o_p2_rx_latency,
   output logic [15:0]                       o_p2_tx_latency
);
   import pdtr_pkg::*;

   // ------------------------------------------------------------
   // Helper functions
   // ------------------------------------------------------------

   // Map a byte address onto a register selector
   function automatic pdtr_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [IDX_W-1:0] idx;
      idx = addr[ADDR_W-1:2];
      if (idx == IDX_ASYM) begin
         decode = SEL_ASYM;
      end else if (idx == IDX_LINK) begin
         decode = SEL_LINK;
      end else if (idx == IDX_DREQ_LO) begin
         decode = SEL_DREQ_LO;
      end else if (idx == IDX_DREQ_HI) begin
         decode = SEL_DREQ_HI;
      end else if (idx == IDX_SYNC_LO) begin
         decode = SEL_SYNC_LO;
      end else if (idx == IDX_SYNC_HI) begin
         decode = SEL_SYNC_HI;
      end else if (idx == IDX_PRSP_LO) begin
         decode = SEL_PRSP_LO;
      end else if (idx == IDX_PRSP_HI) begin
         decode = SEL_PRSP_HI;
      end else if (idx == IDX_RX_LAT) begin
         decode = SEL_RX_LAT;
      end else if (idx == IDX_TX_LAT) begin
         decode = SEL_TX_LAT;
      end else if (idx >= IDX_WIN_LO && idx <= IDX_WIN_HI) begin
         decode = SEL_RSVD;
      end else begin
         decode = SEL_NONE;
      end
   endfunction

   // Merge write data into a 16-bit register under byte strobes
   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] data,
                                         input logic [3:0]  strb);
      merge[7:0]  = strb[0] ? data[7:0]  : old[7:0];
      merge[15:8] = strb[1] ? data[15:8] : old[15:8];
   endfunction

   // Time stamp slot used by each message kind
   function automatic logic [1:0] slot_of(input pdtr_msg_t kind);
      case (kind)
         MSG_DELAY_REQ, MSG_PDELAY_REQ: slot_of = 2'd0;
         MSG_SYNC:                      slot_of = 2'd1;
         MSG_PDELAY_RESP:               slot_of = 2'd2;
         default:                       slot_of = 2'd3;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Register state
   // ------------------------------------------------------------
   logic [15:0]  asym_q;
   logic [15:0]  link_q;
   logic [15:0]  rx_lat_q;
   logic [15:0]  tx_lat_q;
   logic [15:0]  stamp_lo_q [3];
   logic [15:0]  stamp_hi_q [3];
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;
   logic         wr_go;
   pdtr_sel_t    wr_sel;
   pdtr_sel_t    rd_sel;
   logic [1:0]   cap_slot;
   logic [31:0]  rd_word;

   // ------------------------------------------------------------
   // AXI4-Lite write channel
   // ------------------------------------------------------------

   // Address and data are taken independently, commit once both are held
   assign wr_go  = !o_awready && !o_wready && !o_bvalid;
   assign wr_sel = decode(awaddr_q);

   // Write address capture
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_awready <= 1'b1;
         awaddr_q  <= '0;
      end else if (o_awready && i_awvalid) begin
         o_awready <= 1'b0;
         awaddr_q  <= i_awaddr;
      end else if (wr_go) begin
         o_awready <= 1'b1;
      end
   end

   // Write data capture
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_wready <= 1'b1;
         wdata_q  <= '0;
         wstrb_q  <= '0;
      end else if (o_wready && i_wvalid) begin
         o_wready <= 1'b0;
         wdata_q  <= i_wdata;
         wstrb_q  <= i_wstrb;
      end else if (wr_go) begin
         o_wready <= 1'b1;
      end
   end

   // Write response, unmapped addresses answer SLVERR
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_bvalid <= 1'b0;
         o_bresp  <= RESP_OKAY;
      end else if (wr_go) begin
         o_bvalid <= 1'b1;
         o_bresp  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (i_bready) begin
         o_bvalid <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------

   // Software-owned values; reserved words fall through untouched
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         asym_q   <= ASYM_RST;
         link_q   <= LINK_RST;                                         // [RULE4]
         rx_lat_q <= RX_LAT_RST;                                       // [RULE11]
         tx_lat_q <= TX_LAT_RST;                                       // [RULE12]
      end else if (wr_go) begin
         if (wr_sel == SEL_ASYM) begin
            asym_q <= merge(asym_q, wdata_q, wstrb_q);
         end else if (wr_sel == SEL_LINK) begin
            link_q <= merge(link_q, wdata_q, wstrb_q);                 // [RULE4]
         end else if (wr_sel == SEL_RX_LAT) begin
            rx_lat_q <= merge(rx_lat_q, wdata_q, wstrb_q);             // [RULE11]
         end else if (wr_sel == SEL_TX_LAT) begin
            tx_lat_q <= merge(tx_lat_q, wdata_q, wstrb_q);             // [RULE12]
         end
      end
   end

   // Delay values handed to the time stamp logic
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_link_delay    <= LINK_RST;
         o_p2_rx_latency <= RX_LAT_RST;
         o_p2_tx_latency <= TX_LAT_RST;
      end else begin
         o_link_delay    <= link_q;
         o_p2_rx_latency <= rx_lat_q;                                  // [RULE11]
         o_p2_tx_latency <= tx_lat_q;                                  // [RULE12]
      end
   end

   // ------------------------------------------------------------
   // Egress time stamp capture
   // ------------------------------------------------------------
   assign cap_slot = slot_of(i_stamp.kind);

   // Hardware capture wins over a software write in the same cycle
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         for (int s = 0; s < 3; s++) begin
            stamp_lo_q[s] <= STAMP_RST;
            stamp_hi_q[s] <= STAMP_RST;
         end
      end else begin
         for (int s = 0; s < 3; s++) begin
            if (i_stamp.valid && cap_slot == s[1:0]) begin
               stamp_lo_q[s] <= i_stamp.ns[15:0];                      // [RULE5] [RULE7] [RULE9]
               stamp_hi_q[s] <= {i_stamp.sec, i_stamp.ns[29:16]};     // [RULE6] [RULE8] [RULE10] [RULE14]
            end else if (wr_go && wr_sel == pdtr_sel_t'(SEL_DREQ_LO + 2 * s)) begin
               stamp_lo_q[s] <= merge(stamp_lo_q[s], wdata_q, wstrb_q);
            end else if (wr_go && wr_sel == pdtr_sel_t'(SEL_DREQ_HI + 2 * s)) begin
               stamp_hi_q[s] <= merge(stamp_hi_q[s], wdata_q, wstrb_q);
            end
         end
      end
   end

   // ------------------------------------------------------------
   // AXI4-Lite read channel
   // ------------------------------------------------------------
   assign rd_sel = decode(i_araddr);

   // Read multiplexer; reserved and unmapped words read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      case (rd_sel)
         SEL_ASYM:    rd_word[15:0] = asym_q;
         SEL_LINK:    rd_word[15:0] = link_q;
         SEL_DREQ_LO: rd_word[15:0] = stamp_lo_q[0];
         SEL_DREQ_HI: rd_word[15:0] = stamp_hi_q[0];
         SEL_SYNC_LO: rd_word[15:0] = stamp_lo_q[1];
         SEL_SYNC_HI: rd_word[15:0] = stamp_hi_q[1];
         SEL_PRSP_LO: rd_word[15:0] = stamp_lo_q[2];
         SEL_PRSP_HI: rd_word[15:0] = stamp_hi_q[2];
         SEL_RX_LAT:  rd_word[15:0] = rx_lat_q;
         SEL_TX_LAT:  rd_word[15:0] = tx_lat_q;
         default:     rd_word = 32'h0000_0000;                         // [RULE13]
      endcase
   end

   // One read in flight; data registered one cycle after the address
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= RESP_OKAY;
      end else if (o_arready && i_arvalid) begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rdata   <= rd_word;
         o_rresp   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (o_rvalid && i_rready) begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Correction field adjustment
   // ------------------------------------------------------------
   pdtr_corr_adj u_corr_adj (
      .i_clk   (i_clk),
      .i_rst_b (i_rst_b),
      .i_asym  (asym_q),
      .i_req   (i_corr_req),
      .o_rsp   (o_corr_rsp)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_link_write;
      @(posedge i_clk) disable iff (!i_rst_b)
      (wr_go && wr_sel == SEL_LINK && wstrb_q[1:0] == 2'b11)
      |=> ##1 (o_link_delay == $past(wdata_q[15:0], 2));
   endproperty
   a_link_write: assert property (p_link_write) // [RULE4]
      else $error("link delay write not reflected");

   property p_dreq_cap;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_stamp.valid && i_stamp.kind == MSG_DELAY_REQ)
      |=> (stamp_lo_q[0] == $past(i_stamp.ns[15:0]));
   endproperty
   a_dreq_cap: assert property (p_dreq_cap) // [RULE5]
      else $error("delay request low word not captured");

   property p_pdreq_hi;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_stamp.valid && i_stamp.kind == MSG_PDELAY_REQ)
      |=> (stamp_hi_q[0][15:14] == $past(i_stamp.sec))
          && (stamp_hi_q[0][13:0] == $past(i_stamp.ns[29:16]));
   endproperty
   a_pdreq_hi: assert property (p_pdreq_hi) // [RULE6]
      else $error("delay request high word wrong");

   property p_sync_cap;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_stamp.valid && i_stamp.kind == MSG_SYNC)
      |=> (stamp_lo_q[1] == $past(i_stamp.ns[15:0]))
          && (stamp_hi_q[1] == {$past(i_stamp.sec), $past(i_stamp.ns[29:16])});
   endproperty
   a_sync_cap: assert property (p_sync_cap) // [RULE7] [RULE8]
      else $error("sync time stamp not captured");

   property p_prsp_cap;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_stamp.valid && i_stamp.kind == MSG_PDELAY_RESP)
      |=> (stamp_lo_q[2] == $past(i_stamp.ns[15:0]))
          && (stamp_hi_q[2] == {$past(i_stamp.sec), $past(i_stamp.ns[29:16])});
   endproperty
   a_prsp_cap: assert property (p_prsp_cap) // [RULE9] [RULE10]
      else $error("pdelay response time stamp not captured");

   property p_rx_lat_hold;
      @(posedge i_clk) disable iff (!i_rst_b)
      !(wr_go && wr_sel == SEL_RX_LAT) |=> ##1 $stable(o_p2_rx_latency);
   endproperty
   a_rx_lat_hold: assert property (p_rx_lat_hold) // [RULE11]
      else $error("receive latency changed without a write");

   property p_tx_lat_hold;
      @(posedge i_clk) disable iff (!i_rst_b)
      !(wr_go && wr_sel == SEL_TX_LAT) |=> ##1 $stable(o_p2_tx_latency);
   endproperty
   a_tx_lat_hold: assert property (p_tx_lat_hold) // [RULE12]
      else $error("transmit latency changed without a write");

   property p_rsvd_read;
      @(posedge i_clk) disable iff (!i_rst_b)
      (o_arready && i_arvalid && rd_sel == SEL_RSVD)
      |=> o_rvalid && (o_rdata == 32'h0000_0000) && (o_rresp == RESP_OKAY);
   endproperty
   a_rsvd_read: assert property (p_rsvd_read) // [RULE13]
      else $error("reserved word did not read zero");

   property p_cap_wins;
      @(posedge i_clk) disable iff (!i_rst_b)
      (i_stamp.valid && i_stamp.kind == MSG_SYNC && wr_go && wr_sel == SEL_SYNC_LO)
      |=> (stamp_lo_q[1] == $past(i_stamp.ns[15:0]));
   endproperty
   a_cap_wins: assert property (p_cap_wins) // [RULE14]
      else $error("software write beat hardware capture");

endmodule

//--- tb/pdtr_link_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// Link partner: egress event source
// ------------------------------------------------------------
module pdtr_link_model (
   input  wire logic                i_clk,
   input  wire logic                i_rst_b,
   input  wire logic                i_send,
   input  wire pdtr_pkg::pdtr_msg_t i_kind,
   input  wire logic [31:0]         i_time,
   output pdtr_pkg::pdtr_stamp_t    o_stamp
);
   import pdtr_pkg::*;
   // One pulse per departing frame; idle payload toggles so stale data shows
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_stamp <= '0;
      end else if (i_send) begin
         o_stamp <= {1'b1, i_kind, i_time};
      end else begin
         o_stamp <= {1'b0, o_stamp.kind, ~o_stamp.sec, ~o_stamp.ns};
      end
   end
endmodule

//--- tb/pdtr_regs_test.sv
`timescale 1ns/10ps
module pdtr_regs_test;
   import pdtr_pkg::*;
   logic           clk = 0, rst_b = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, snd = 0;
   logic [12:0]    awa = 0, ara = 0;
   logic [31:0]    wd = 0, tm = 0, rdat, seed = 32'h0001_0E3C;
   logic [15:0]    ld, rxl, txl;
   logic [1:0]     br, rr;
   logic           awr, wrd, bv, arr, rv;
   pdtr_msg_t      knd = MSG_SYNC;
   pdtr_stamp_t    stp;
   pdtr_corr_req_t crq = '0;
   pdtr_corr_rsp_t crs;
   int             miscompares = 0, num_checks = 0, cyc = 0;

   pdtr_link_model peer (.i_clk(clk), .i_rst_b(rst_b), .i_send(snd), .i_kind(knd),
      .i_time(tm), .o_stamp(stp));
   pdtr_regs dut (.i_clk(clk), .i_rst_b(rst_b), .i_awvalid(awv), .o_awready(awr),
      .i_awaddr(awa), .i_wvalid(wv), .o_wready(wrd), .i_wdata(wd), .i_wstrb(4'hF),
      .o_bvalid(bv), .i_bready(bry), .o_bresp(br), .i_arvalid(arv), .o_arready(arr),
      .i_araddr(ara), .o_rvalid(rv), .i_rready(rry), .o_rdata(rdat), .o_rresp(rr),
      .i_stamp(stp), .i_corr_req(crq), .o_corr_rsp(crs), .o_link_delay(ld),
      .o_p2_rx_latency(rxl), .o_p2_tx_latency(txl));

   // Clock and hang guard
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         print_verdict();
      end
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   // Low word address of the pair that a message kind fills
   function automatic logic [12:0] lo(pdtr_msg_t k);
      return (k == MSG_SYNC) ? 13'h1930 : (k == MSG_PDELAY_RESP) ? 13'h1940 : 13'h1920;
   endfunction

   // Expected correction field for a given asymmetry word
   function automatic logic [63:0] ecorr(logic [15:0] a, logic ing, pdtr_msg_t k,
                                         logic [63:0] f);
      logic [63:0] s;
      s = {33'h0, a[14:0], 16'h0};
      if (a[15]) s = -s;
      if (ing && (k == MSG_SYNC || k == MSG_PDELAY_RESP)) return f + s;
      if (!ing && (k == MSG_DELAY_REQ || k == MSG_PDELAY_REQ)) return f - s;
      return f;
   endfunction

   task automatic cmp(input logic [63:0] g, input logic [63:0] e);
      num_checks++;
      if (g !== e) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // AXI4-Lite write: address and data offered together, response checked
   task automatic wr(input logic [12:0] a, input logic [31:0] d, input logic [1:0] er);
      bit pa, pw;
      pa = 1;
      pw = 1;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      while (pa | pw) begin
         @(posedge clk);
         if (pa && awr === 1'b1) begin
            pa = 0;
            awv <= 0;
         end
         if (pw && wrd === 1'b1) begin
            pw = 0;
            wv <= 0;
         end
      end
      bry <= 1;
      do @(posedge clk); while (bv !== 1'b1);
      bry <= 0;
      cmp(br, er);
   endtask

   // AXI4-Lite read with expected data and response
   task automatic rd(input logic [12:0] a, input logic [31:0] e, input logic [1:0] er);
      ara <= a;
      arv <= 1;
      do @(posedge clk); while (arr !== 1'b1);
      arv <= 0;
      rry <= 1;
      do @(posedge clk); while (rv !== 1'b1);
      rry <= 0;
      cmp(rdat, e);
      cmp(rr, er);
   endtask

   task automatic stamp(input pdtr_msg_t k, input logic [31:0] t);
      knd <= k;
      tm <= t;
      snd <= 1;
      @(posedge clk);
      snd <= 0;
      repeat (2) @(posedge clk);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [31:0] v;
      logic [15:0] a;
      logic [63:0] f;
      logic [12:0] ad [10] = '{13'h1910, 13'h1918, 13'h1920, 13'h1928, 13'h1930,
                               13'h1938, 13'h1940, 13'h1948, 13'h1980, 13'h1988};
      repeat (12) @(posedge clk);
      rst_b <= 1;
      @(posedge clk);
      for (int i = 0; i < 10; i++)
         rd(ad[i], (i == 8) ? 32'h019F : (i == 9) ? 32'h002D : 32'h0, RESP_OKAY);
      $display("test reset values done");
      repeat (4) begin
         v = rnd();
         wr(13'h1918, v, RESP_OKAY);
         wr(13'h1980, ~v, RESP_OKAY);
         wr(13'h1988, v >> 7, RESP_OKAY);
         @(negedge clk);
         cmp({ld, rxl, txl}, {v[15:0], ~v[15:0], v[22:7]});
         @(posedge clk);
         rd(13'h1980, {16'h0, ~v[15:0]}, RESP_OKAY);
      end
      wr(13'h1950, v, RESP_OKAY);
      rd(13'h1950, 32'h0, RESP_OKAY);
      rd(13'h1914, 32'h0, RESP_OKAY);
      rd(13'h0000, 32'h0, RESP_SLVERR);
      wr(13'h0004, ~v, RESP_SLVERR);
      rd(13'h1918, {16'h0, v[15:0]}, RESP_OKAY);
      $display("test delays and reserved done");
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         stamp(pdtr_msg_t'(i), rnd());
         stamp(pdtr_msg_t'(i), v);
         rd(lo(pdtr_msg_t'(i)), {16'h0, v[15:0]}, RESP_OKAY);
         rd(lo(pdtr_msg_t'(i)) + 13'h8, {16'h0, v[31:30], v[29:16]}, RESP_OKAY);
      end
      stamp(MSG_OTHER, ~v);
      rd(13'h1940, {16'h0, v[15:0]}, RESP_OKAY);
      // Capture and software write of the Sync low word in one cycle
      fork
         wr(13'h1930, ~v, RESP_OKAY);
         stamp(MSG_SYNC, v);
      join
      rd(13'h1930, {16'h0, v[15:0]}, RESP_OKAY);
      $display("test stamps done");
      for (int i = 0; i < 6; i++) begin
         a = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h7FFF : 16'(rnd());
         wr(13'h1910, {16'h0, a}, RESP_OKAY);
         for (int j = 0; j < 10; j++) begin
            f = {rnd(), rnd()};
            crq <= {1'b1, j[0], pdtr_msg_t'(j >> 1), f};
            @(posedge clk);
            crq.valid <= 0;
            @(negedge clk);
            cmp(crs.field, ecorr(a, j[0], pdtr_msg_t'(j >> 1), f));
            cmp(crs.valid, 1'b1);
            @(posedge clk);
         end
      end
      $display("test correction done");
      print_verdict();
   end
endmodule
